// ===== sltp_gen.v
// Test pattern generator for the serial link output path.
// Assumes a byte-wide register write port in the mclk domain, and that
// the datapath gives a one-cycle advance strobe per frame/symbol/octet.
// Summary of operation
// [R1] Control bits [3:0] pick the pattern; zero passes normal data through.
// [R2] Control bits [5:4] pick where the pattern enters the datapath.
// [R3] Modes 3 to 7 run PRBS31, 23, 15, 9 and 7 from their fixed seeds.
// [R4] Mode 8 is a ramp of step one wrapping at 16, 10 or 8 bits by point.
// [R5] Mode 14 plays user words one to four and then repeats them.
// [R6] Mode 15 plays user words one to four once and then sends zeros.
// [R7] User words are used whole at samples, upper 10 or 7 bits elsewhere.
// [R8] At the sample point one value fills a whole frame and steps per frame.
// [R9] At the 10-bit point the pattern steps once per symbol.
// [R10] At the octet point the pattern steps once per octet.
// [R11] PRBS octets are the sample sequence split high byte first.
// [R12] An active pattern replaces normal data at the chosen point.
// [R13] Leaving test mode needs a soft reset write of 0x81, which self clears.
// [R14] A PRBS reloads its seed whenever its mode is newly chosen.
`default_nettype none
`include "sltp_regs.vh"
module sltp_gen (
   input  wire        mclk,
   input  wire        rstn,
   input  wire        reg_wr,
   input  wire [15:0] reg_addr,
   input  wire [7:0]  reg_wdata,
   input  wire [15:0] user_pattern_word1,
   input  wire [15:0] user_pattern_word2,
   input  wire [15:0] user_pattern_word3,
   input  wire [15:0] user_pattern_word4,
   input  wire        adv_strobe,
   input  wire [15:0] norm_data,
   output reg  [7:0]  ctrl_rdata,
   output reg  [15:0] out_data,
   output reg         test_active,
   output reg         soft_reset_pulse
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg  [7:0]  ctrl_r;
   reg  [3:0]  mode_last_r;
   reg  [15:0] ramp_r;
   reg  [1:0]  up_idx_r;
   reg         up_done_r;
   reg         half_r;        // Octet point: low byte selected
   reg         alt_r;         // Checker/toggle phase
   reg         exit_armed_r;
   wire [3:0]  mode = ctrl_r[`SLTP_MODE_HI:`SLTP_MODE_LO];          // [R1]
   wire [1:0]  inj  = ctrl_r[`SLTP_INJ_HI:`SLTP_INJ_LO];            // [R2]
   wire        newmode = (mode != mode_last_r);
   wire        octet = (inj == `SLTP_INJ_OCTET);
   wire        sym_pt = (inj == `SLTP_INJ_SYMBOL);                  // [R9]
   // Whole PRBS sample consumed: every step except high byte at octet point
   wire        prbs_step = adv_strobe & ~(octet & ~half_r);         // [R11]
   wire [15:0] w31, w23, w15, w9, w7;
   // ----------------------------------------
   // PRBS generators
   // ----------------------------------------
   // Each reloads its seed when its mode is newly selected
   sltp_prbs #(.W(31), .T(28), .SEED(`SLTP_SEED31)) u_p31 (.mclk(mclk), .rstn(rstn),
      .load(newmode & (mode == `SLTP_MODE_PRBS31)), .step(prbs_step), .sym10(sym_pt),
      .word(w31)); // [R3] [R14]
   sltp_prbs #(.W(23), .T(18), .SEED(`SLTP_SEED23)) u_p23 (.mclk(mclk), .rstn(rstn),
      .load(newmode & (mode == `SLTP_MODE_PRBS23)), .step(prbs_step), .sym10(sym_pt),
      .word(w23)); // [R3] [R14]
   sltp_prbs #(.W(15), .T(14), .SEED(`SLTP_SEED15)) u_p15 (.mclk(mclk), .rstn(rstn),
      .load(newmode & (mode == `SLTP_MODE_PRBS15)), .step(prbs_step), .sym10(sym_pt),
      .word(w15)); // [R3] [R14]
   sltp_prbs #(.W(9), .T(5), .SEED(`SLTP_SEED9)) u_p9 (.mclk(mclk), .rstn(rstn),
      .load(newmode & (mode == `SLTP_MODE_PRBS9)), .step(prbs_step), .sym10(sym_pt),
      .word(w9)); // [R3] [R14]
   sltp_prbs #(.W(7), .T(6), .SEED(`SLTP_SEED7)) u_p7 (.mclk(mclk), .rstn(rstn),
      .load(newmode & (mode == `SLTP_MODE_PRBS7)), .step(prbs_step), .sym10(sym_pt),
      .word(w7)); // [R3] [R14]
   // ----------------------------------------
   // Register writes and soft reset
   // ----------------------------------------
   // Nonzero to zero only takes effect after a soft reset write
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ctrl_r           <= `SLTP_CTRL_RESET;
         exit_armed_r     <= 1'b0;
         soft_reset_pulse <= 1'b0;
         ctrl_rdata       <= `SLTP_CTRL_RESET;
      end else begin
         soft_reset_pulse <= 1'b0;
         ctrl_rdata       <= ctrl_r;
         if (reg_wr && reg_addr == `SLTP_ADDR_CFG && reg_wdata == `SLTP_SOFT_RESET_VAL) begin
            soft_reset_pulse <= 1'b1;                                   // [R13] self clears
            ctrl_r           <= `SLTP_CTRL_RESET;
            exit_armed_r     <= 1'b0;
         end else if (reg_wr && reg_addr == `SLTP_ADDR_CTRL) begin
            if (reg_wdata[`SLTP_MODE_HI:`SLTP_MODE_LO] == `SLTP_MODE_OFF && mode != `SLTP_MODE_OFF) begin
               exit_armed_r <= 1'b1;                                    // [R13] held until soft reset or a nonzero mode write
               ctrl_r[`SLTP_INJ_HI:`SLTP_INJ_LO] <= reg_wdata[`SLTP_INJ_HI:`SLTP_INJ_LO];
            end else begin
               ctrl_r       <= reg_wdata;
               exit_armed_r <= 1'b0;
            end
         end
      end
   end
   // ----------------------------------------
   // Sequencing state
   // ----------------------------------------
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         mode_last_r <= `SLTP_MODE_OFF;
         ramp_r      <= 16'h0000;
         up_idx_r    <= 2'h0;
         up_done_r   <= 1'b0;
         half_r      <= 1'b0;
         alt_r       <= 1'b0;
      end else begin
         mode_last_r <= mode;
         if (newmode) begin
            ramp_r    <= 16'h0000;
            up_idx_r  <= 2'h0;
            up_done_r <= 1'b0;
            half_r    <= 1'b0;
            alt_r     <= 1'b0;
         end else if (adv_strobe) begin
            // One element per frame, symbol or octet
            ramp_r   <= ramp_r + 16'h0001;                              // [R4] [R8] [R9] [R10]
            alt_r    <= ~alt_r;
            half_r   <= octet ? ~half_r : 1'b0;
            up_idx_r <= up_idx_r + 2'h1;                                // [R5]
            if (up_idx_r == 2'h3)
               up_done_r <= 1'b1;                                       // [R6]
         end
      end
   end
   // ----------------------------------------
   // Pattern selection and width shaping
   // ----------------------------------------
   reg [15:0] raw;
   reg [15:0] upw;
   reg [15:0] shaped;
   always @* begin
      case (up_idx_r)
         2'h0:    upw = user_pattern_word1;
         2'h1:    upw = user_pattern_word2;
         2'h2:    upw = user_pattern_word3;
         default: upw = user_pattern_word4;
      endcase
      raw = 16'h0000;
      case (mode)
         `SLTP_MODE_CHECKER:  raw = alt_r ? `SLTP_CHECK_B : `SLTP_CHECK_A;
         `SLTP_MODE_TOGGLE:   raw = alt_r ? `SLTP_ONES : 16'h0000;
         `SLTP_MODE_PRBS31:   raw = w31;
         `SLTP_MODE_PRBS23:   raw = w23;
         `SLTP_MODE_PRBS15:   raw = w15;
         `SLTP_MODE_PRBS9:    raw = w9;
         `SLTP_MODE_PRBS7:    raw = w7;
         `SLTP_MODE_RAMP:     raw = ramp_r;
         `SLTP_MODE_USER_REP: raw = upw;                                // [R5]
         `SLTP_MODE_USER_ONCE: raw = up_done_r ? 16'h0000 : upw;        // [R6]
         default:             raw = 16'h0000;
      endcase
      // Fit to the width of the injection point, low-justified
      case (inj)
         `SLTP_INJ_SYMBOL: begin
            if (mode == `SLTP_MODE_RAMP || mode == `SLTP_MODE_CHECKER || mode == `SLTP_MODE_TOGGLE)
               shaped = {6'h00, raw[9:0]};                              // [R4] [R9]
            else
               shaped = {6'h00, raw[15:6]};                             // [R7]
         end
         `SLTP_INJ_OCTET: begin
            if (mode >= `SLTP_MODE_PRBS31 && mode <= `SLTP_MODE_PRBS7)
               shaped = {8'h00, half_r ? raw[7:0] : raw[15:8]};         // [R11]
            else if (mode == `SLTP_MODE_USER_REP || mode == `SLTP_MODE_USER_ONCE)
               shaped = {9'h000, raw[15:9]};                            // [R7]
            else
               shaped = {8'h00, raw[7:0]};                              // [R4] [R10]
         end
         default: shaped = raw;                                         // [R8]
      endcase
   end
   // ----------------------------------------
   // Output substitution
   // ----------------------------------------
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         out_data    <= 16'h0000;
         test_active <= 1'b0;
      end else begin
         test_active <= (mode != `SLTP_MODE_OFF);
         out_data    <= (mode != `SLTP_MODE_OFF) ? shaped : norm_data;  // [R12] [R1]
      end
   end
endmodule
`default_nettype wire

// ===== sltp_gen_properties.sv
// Port checker for the serial link test pattern generator.
// Assumes it is bound to every sltp_gen instance.
`default_nettype none
module sltp_chk (
   input wire logic        mclk,
   input wire logic        rstn,
   input wire logic        reg_wr,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        adv_strobe,
   input wire logic [15:0] norm_data,
   input wire logic [7:0]  ctrl_rdata,
   input wire logic [15:0] out_data,
   input wire logic        test_active,
   input wire logic        soft_reset_pulse
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking dcb @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   // -----------------------------
   // Soft reset and control register
   // -----------------------------
   a_pulse_single: assert property (soft_reset_pulse |=> !soft_reset_pulse)
      else $error("soft reset pulse longer than one cycle");
   a_pulse_cause: assert property (reg_wr && reg_addr == 16'h0000 && reg_wdata == 8'h81
      |-> ##[1:2] soft_reset_pulse) else $error("soft reset write gave no pulse");
   a_ctrl_cleared: assert property (soft_reset_pulse |-> ##[0:2] ctrl_rdata == 8'h00)
      else $error("soft reset left control set");
   a_zero_refused: assert property (reg_wr && reg_addr == 16'h0573 && reg_wdata[3:0] == 4'h0
      && test_active |-> ##3 ctrl_rdata[3:0] != 4'h0) else $error("mode zero taken");
   a_active_flag: assert property (ctrl_rdata[3:0] != 4'h0 |-> ##[0:1] test_active)
      else $error("test mode without active flag");
   // -----------------------------
   // Pattern output
   // -----------------------------
   a_pass_normal: assert property (ctrl_rdata == 8'h00 && $past(ctrl_rdata) == 8'h00
      && $past(ctrl_rdata, 2) == 8'h00 && $past(rstn, 3) |-> out_data == $past(norm_data))
      else $error("normal data not passed");
   a_checker_vals: assert property (ctrl_rdata == 8'h01 && $past(ctrl_rdata, 2) == 8'h01
      |-> out_data == 16'h5555 || out_data == 16'haaaa) else $error("bad checkerboard");
   a_octet_upper: assert property (ctrl_rdata[5:4] == 2'h2 && ctrl_rdata[3:0] != 4'h0
      && $past(ctrl_rdata, 2) == ctrl_rdata |-> out_data[15:8] == 8'h00)
      else $error("octet word upper bits set");
   a_hold_no_adv: assert property (ctrl_rdata[3:0] != 4'h0 && $past(ctrl_rdata, 3) == ctrl_rdata
      && !$past(adv_strobe) && !$past(adv_strobe, 2) && !$past(adv_strobe, 3)
      |-> $stable(out_data)) else $error("pattern moved without advance");
   c_soft_reset: cover property (soft_reset_pulse);
   c_checker: cover property (ctrl_rdata == 8'h01 && adv_strobe);
   c_prbs_octet: cover property (ctrl_rdata == 8'h26 && adv_strobe);
endmodule
bind sltp_gen sltp_chk u_chk (.*);
`default_nettype wire

// ===== sltp_prbs.v
// One Fibonacci PRBS generator, x^W + x^T + 1, 16 output bits per word.
// Assumes load and step are single-cycle strobes in the mclk domain;
// sym10 makes a step consume 10 bits instead of 16.
`default_nettype none
module sltp_prbs #(
   parameter W = 9,
   parameter T = 5,
   parameter [W-1:0] SEED = {W{1'b1}}
) (
   input  wire        mclk,
   input  wire        rstn,
   input  wire        load,
   input  wire        step,
   input  wire        sym10,
   output wire [15:0] word
);
   reg  [W-1:0] state_r;
   reg  [W-1:0] st;
   reg  [W-1:0] st10;
   reg  [15:0]  wd;
   integer      i;
   // Sixteen shifts; oldest stream bit sits in bit 15 and goes out first
   always @* begin
      st   = state_r;
      st10 = state_r;
      wd   = 16'h0000;
      for (i = 0; i < 16; i = i + 1) begin
         wd = {wd[14:0], st[0]};
         st = {st[0] ^ st[W-T], st[W-1:1]};
         if (i == 9)
            st10 = st;                  // State after a 10-bit symbol
      end
   end
   assign word = wd;
   // Seed on load, advance on step
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_r <= SEED;
      end else if (load) begin
         state_r <= SEED;
      end else if (step) begin
         state_r <= sym10 ? st10 : st;
      end
   end
endmodule
`default_nettype wire

// ===== sltp_regs.vh
// Constants for the serial link test pattern generator.
// Assumes inclusion by bare name from the design files.
`ifndef SLTP_REGS_VH
`define SLTP_REGS_VH
// ----------------------------------------
// Register offsets and fields
// ----------------------------------------
`define SLTP_ADDR_CTRL      16'h0573
`define SLTP_ADDR_CFG       16'h0000
`define SLTP_SOFT_RESET_VAL 8'h81
`define SLTP_CTRL_RESET     8'h00
`define SLTP_MODE_HI        3
`define SLTP_MODE_LO        0
`define SLTP_INJ_HI         5
`define SLTP_INJ_LO         4
// ----------------------------------------
// Mode codes
// ----------------------------------------
`define SLTP_MODE_OFF       4'h0
`define SLTP_MODE_CHECKER   4'h1
`define SLTP_MODE_TOGGLE    4'h2
`define SLTP_MODE_PRBS31    4'h3
`define SLTP_MODE_PRBS23    4'h4
`define SLTP_MODE_PRBS15    4'h5
`define SLTP_MODE_PRBS9     4'h6
`define SLTP_MODE_PRBS7     4'h7
`define SLTP_MODE_RAMP      4'h8
`define SLTP_MODE_USER_REP  4'he
`define SLTP_MODE_USER_ONCE 4'hf
// ----------------------------------------
// Injection points
// ----------------------------------------
`define SLTP_INJ_SAMPLE     2'h0
`define SLTP_INJ_SYMBOL     2'h1
`define SLTP_INJ_OCTET      2'h2
// ----------------------------------------
// Pattern values and seeds
// ----------------------------------------
`define SLTP_CHECK_A        16'h5555
`define SLTP_CHECK_B        16'haaaa
`define SLTP_ONES           16'hffff
`define SLTP_SEED31         31'h0003afff
`define SLTP_SEED23         23'h003aff
`define SLTP_SEED15         15'h03af
`define SLTP_SEED9          9'h092
`define SLTP_SEED7          7'h07
`endif

// ===== sltp_rx_model.sv
// Far side receiver model: paces elements and latches received words.
// Assumes step_req is a one-cycle request from the bench.
`default_nettype none
module sltp_rx_model (
   input  wire logic        mclk,
   input  wire logic        rstn,
   input  wire logic        step_req,
   input  wire logic [15:0] data_in,
   output var  logic        adv_strobe,
   output var  logic [15:0] rx_word
);
   timeunit 1ns;
   timeprecision 100ps;
   // Advance request and word capture
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         adv_strobe <= 1'b0;
         rx_word    <= 16'h0000;
      end else begin
         adv_strobe <= step_req;
         rx_word    <= data_in;
      end
   end
endmodule
`default_nettype wire

// ===== tb_serial_link_test_pattern_gen.sv
// Self-checking bench for the test pattern generator.
// Assumes sltp_gen, sltp_rx_model and the bound checker are compiled.
`default_nettype none
module tb_serial_link_test_pattern_gen;
   timeunit 1ns;
   timeprecision 100ps;
   logic        mclk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, step_req = 1'b0;
   logic        adv_strobe, test_active, srp;
   logic [7:0]  reg_wdata = 8'h00, ctrl_rdata;
   logic [15:0] reg_addr = 16'h0000, norm_data = 16'h1234, out_data, rx_word;
   logic [15:0] up [4] = '{16'hc3c0, 16'h5a40, 16'h9f80, 16'h2600};
   logic [15:0] z [6] = '{6{16'h0000}};
   int          n_fail = 0, check_count = 0, cycles = 0, n_srp = 0;
   // Clock, timeout and pulse count
   initial forever #12.5 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles++;
      if (srp === 1'b1) n_srp++;
      if (cycles == 20000) begin
         n_fail++;
         give_verdict;
      end
   end
   sltp_gen dut (.mclk(mclk), .rstn(rstn), .reg_wr(reg_wr), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .user_pattern_word1(up[0]), .user_pattern_word2(up[1]),
      .user_pattern_word3(up[2]), .user_pattern_word4(up[3]), .adv_strobe(adv_strobe),
      .norm_data(norm_data), .ctrl_rdata(ctrl_rdata), .out_data(out_data),
      .test_active(test_active), .soft_reset_pulse(srp));
   sltp_rx_model rx (.mclk(mclk), .rstn(rstn), .step_req(step_req), .data_in(out_data),
      .adv_strobe(adv_strobe), .rx_word(rx_word));
   // -----------------------------
   // Shared tasks
   // -----------------------------
   task automatic give_verdict;
      $display("checks %0d failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      repeat (5) @(posedge mclk);
   endtask
   task automatic step;
      step_req <= 1'b1;
      @(posedge mclk);
      step_req <= 1'b0;
      repeat (5) @(posedge mclk);
   endtask
   task automatic seq(input logic [7:0] c, input int n, input logic [15:0] e [6]);
      wr(16'h0573, c);
      chk("control", {8'h00, c}, {8'h00, ctrl_rdata});
      for (int i = 0; i < n; i++) begin
         chk("word", e[i], rx_word);
         step;
      end
   endtask
   // -----------------------------
   // Scenarios
   // -----------------------------
   task automatic t_fixed;
      seq(8'h01, 3, '{16'h5555, 16'haaaa, 16'h5555, 0, 0, 0});
      seq(8'h02, 2, '{16'h0000, 16'hffff, 0, 0, 0, 0});
      seq(8'h11, 2, '{16'h0155, 16'h02aa, 0, 0, 0, 0});
      seq(8'h22, 3, '{16'h0000, 16'h00ff, 16'h0000, 0, 0, 0});
   endtask
   task automatic t_prbs;
      seq(8'h06, 4, '{16'h496f, 16'hc9a9, 16'h980c, 16'h651a, 0, 0});
      seq(8'h04, 2, '{16'hff5c, 16'h0029, 0, 0, 0, 0});
      seq(8'h26, 4, '{16'h0049, 16'h006f, 16'h00c9, 16'h00a9, 0, 0});
      seq(8'h14, 2, '{16'h03fd, 16'h01c0, 0, 0, 0, 0});
      seq(8'h16, 2, '{16'h0125, 16'h02fc, 0, 0, 0, 0});
      for (int m = 3; m < 8; m += 2) seq(m[7:0], 0, z);
   endtask
   task automatic t_ramp;
      logic [15:0] r0;
      wr(16'h0573, 8'h28);
      r0 = rx_word;
      repeat (256) step;
      chk("ramp wrap", r0, rx_word);
      step;
      chk("ramp step", {8'h00, r0[7:0] + 8'h01}, rx_word);
   endtask
   task automatic t_user;
      seq(8'h0e, 5, '{up[0], up[1], up[2], up[3], up[0], 0});
      seq(8'h1f, 5, '{up[0] >> 6, up[1] >> 6, up[2] >> 6, up[3] >> 6, 0, 0});
      seq(8'h2e, 5, '{up[0] >> 9, up[1] >> 9, up[2] >> 9, up[3] >> 9, up[0] >> 9, 0});
   endtask
   task automatic t_soft;
      wr(16'h0573, 8'h00);
      chk("held active", 16'h0001, {15'h0000, test_active});
      wr(16'h0000, 8'h81);
      chk("pulses", 16'h0001, n_srp[15:0]);
      chk("control", 16'h0000, {8'h00, ctrl_rdata});
      chk("normal", norm_data, rx_word);
   endtask
   // Main sequence
   initial begin
      repeat (4) @(posedge mclk);
      rstn <= 1'b1;
      repeat (2) @(posedge mclk);
      chk("control reset", 16'h0000, {8'h00, ctrl_rdata});
      t_fixed;
      t_prbs;
      t_ramp;
      t_user;
      t_soft;
      give_verdict;
   end
endmodule
`default_nettype wire
